//--- hdl/irq_steer_pkg.sv
// package: register map and source layout for interrupt mode steering
package irq_steer_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_INT_MODE = 12'h000;
  localparam logic [11:0] OFS_EXT_MODE = 12'h004;
  // reset values
  localparam logic [31:0] RST_INT_MODE = 32'h0000_0000;
  localparam logic [31:0] RST_EXT_MODE = 32'h0000_0000;
  // implemented bits
  // 31:14 minus nothing, 6:3 and 0: 23 live bits
  localparam logic [31:0] INT_MODE_MASK = 32'hffff_c079;
  localparam logic [31:0] EXT_MODE_MASK = 32'h0000_003f;
  // field positions
  localparam int POS_WATCHDOG = 31;
  localparam int POS_TIMER0 = 25;
  localparam int POS_DMA0 = 19;
  localparam int POS_CIPHER = 18;
  localparam int POS_ETH0_TX = 14;
  localparam int POS_HS_UART_TX = 3;
  localparam int POS_I2C = 0;
  localparam int NUM_EXT = 6;
  localparam int NUM_INT_IMPL = 23;
endpackage : irq_steer_pkg

//--- hdl/interrupt_mode_steering.sv
// interrupt mode steering: mode registers and irq/fiq routing
`timescale 1ns/1ps

module interrupt_mode_steering (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // internal sources in mode-register bit order, reserved bits ignored
  input wire logic [31:0] intReq,
  // external lines, asynchronous pins
  input wire logic [5:0] extReq,
  // core interrupt inputs
  output logic irqOut,
  output logic fiqOut
);
  import irq_steer_pkg::*;

  // ****************************************
  // register file
  // ****************************************
  logic [31:0] intMode_q;
  logic [31:0] intMode_d;
  logic [5:0] extMode_q;
  logic [5:0] extMode_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic pslverr_d;

  wire setup = psel && !penable;
  wire hitInt = paddr == OFS_INT_MODE;
  wire hitExt = paddr == OFS_EXT_MODE;
  wire hitAny = hitInt || hitExt;
  // write commits at the access edge, when pready_q is high
  wire commit = psel && penable && pready_q;
  wire wrInt = commit && pwrite && hitInt;
  wire wrExt = commit && pwrite && hitExt;

  assign intMode_d = wrInt ? (pwdata & INT_MODE_MASK) : intMode_q;
  assign extMode_d = wrExt ? pwdata[NUM_EXT-1:0] : extMode_q;
  assign prdata_d = !setup ? prdata_q :
                    hitInt ? intMode_q :
                    hitExt ? {26'h0, extMode_q} : 32'h0000_0000;
  // error flag stands only in the access cycle, like pready
  assign pslverr_d = setup && !hitAny;

  always_ff @(posedge clk) begin
    if (rst) begin
      intMode_q <= RST_INT_MODE;
      extMode_q <= RST_EXT_MODE[NUM_EXT-1:0];
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      intMode_q <= intMode_d;
      extMode_q <= extMode_d;
      prdata_q <= prdata_d;
      pready_q <= setup;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ****************************************
  // request steering
  // ****************************************
  logic [5:0] extMeta_q;
  logic [5:0] extSync_q;
  logic irq_q;
  logic fiq_q;

  // level path, two-stage sync on pins
  always_ff @(posedge clk) begin
    if (rst) begin
      extMeta_q <= 6'h00;
      extSync_q <= 6'h00;
    end else begin
      extMeta_q <= extReq;
      extSync_q <= extMeta_q;
    end
  end

  wire [31:0] intLive = intReq & INT_MODE_MASK;
  wire [31:0] intFiq = intLive & intMode_q;
  wire [31:0] intIrq = intLive & ~intMode_q;
  wire [5:0] extFiq = extSync_q & extMode_q;
  wire [5:0] extIrq = extSync_q & ~extMode_q;
  wire fiqD = (|intFiq) || (|extFiq);
  wire irqD = (|intIrq) || (|extIrq);

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
      fiq_q <= 1'b0;
    end else begin
      irq_q <= irqD;
      fiq_q <= fiqD;
    end
  end

  assign irqOut = irq_q;
  assign fiqOut = fiq_q;

  // ****************************************
  // checks
  // ****************************************
  // reset value
  AST_RESET_ZERO: assert property (@(posedge clk)
    $past(rst) |-> intMode_q == 32'h0 && extMode_q == 6'h0)
    else $error("mode registers not zero after reset");
  AST_RSVD_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (intMode_q & ~INT_MODE_MASK) == 32'h0)
    else $error("reserved internal mode bit set");
  AST_INT_FIQ: assert property (@(posedge clk) disable iff (rst)
    |(intReq & INT_MODE_MASK & intMode_q) |=> fiqOut)
    else $error("fiq missing for fiq-mode source");
  AST_INT_IRQ: assert property (@(posedge clk) disable iff (rst)
    |(intReq & INT_MODE_MASK & ~intMode_q) |=> irqOut)
    else $error("irq missing for irq-mode source");
  AST_RSVD_QUIET: assert property (@(posedge clk) disable iff (rst)
    (intReq & INT_MODE_MASK) == 32'h0 && extSync_q == 6'h0 |=>
    !irqOut && !fiqOut)
    else $error("output raised without live request");
  // external line reaches fiq three cycles later
  AST_EXT_FIQ: assert property (@(posedge clk) disable iff (rst)
    extReq[0] && extMode_q[0] && !wrExt ##1 extReq[0] && !wrExt
    ##1 extMode_q[0] |=> fiqOut)
    else $error("external fiq not steered");
  AST_LEVEL_HOLD: assert property (@(posedge clk) disable iff (rst)
    (intReq[POS_WATCHDOG] && !intMode_q[POS_WATCHDOG])[*2] |-> irqOut)
    else $error("irq dropped while watchdog level held");
  AST_WD_WRITE: assert property (@(posedge clk) disable iff (rst)
    wrInt |=> intMode_q[POS_WATCHDOG] == $past(pwdata[POS_WATCHDOG]))
    else $error("watchdog mode bit not written");
  AST_INT_WRITE: assert property (@(posedge clk) disable iff (rst)
    wrInt |=> intMode_q == ($past(pwdata) & INT_MODE_MASK))
    else $error("internal mode write wrong");
  AST_EXT_WRITE: assert property (@(posedge clk) disable iff (rst)
    wrExt |=> extMode_q == $past(pwdata[5:0]))
    else $error("external mode write wrong");
  // a lone source raises exactly one output
  AST_ONE_OUT: assert property (@(posedge clk) disable iff (rst)
    $onehot(intReq & INT_MODE_MASK) && extSync_q == 6'h0 |=>
    irqOut != fiqOut)
    else $error("lone request did not pick exactly one output");
  AST_TIMER_FIQ: assert property (@(posedge clk) disable iff (rst)
    intReq[POS_TIMER0] && intMode_q[POS_TIMER0] |=> fiqOut)
    else $error("timer fiq not steered");
  AST_DMA_FIQ: assert property (@(posedge clk) disable iff (rst)
    intReq[POS_DMA0] && intMode_q[POS_DMA0] |=> fiqOut)
    else $error("dma fiq not steered");
  AST_CIPHER_FIQ: assert property (@(posedge clk) disable iff (rst)
    intReq[POS_CIPHER] && intMode_q[POS_CIPHER] |=> fiqOut)
    else $error("cipher fiq not steered");
  AST_ETH_IRQ: assert property (@(posedge clk) disable iff (rst)
    intReq[POS_ETH0_TX] && !intMode_q[POS_ETH0_TX] |=> irqOut)
    else $error("ethernet irq not steered");
  AST_UART_FIQ: assert property (@(posedge clk) disable iff (rst)
    intReq[POS_HS_UART_TX] && intMode_q[POS_HS_UART_TX] |=> fiqOut)
    else $error("uart fiq not steered");
  AST_I2C_IRQ: assert property (@(posedge clk) disable iff (rst)
    intReq[POS_I2C] && !intMode_q[POS_I2C] |=> irqOut)
    else $error("i2c irq not steered");
  AST_EXT_IRQ: assert property (@(posedge clk) disable iff (rst)
    extSync_q[5] && !extMode_q[5] |=> irqOut)
    else $error("external irq not steered");
endmodule : interrupt_mode_steering

//--- testbench/core_irq_model.sv
// partner: core interrupt inputs sampling irq and fiq levels
`timescale 1ns/1ps
module core_irq_model (
  // core side
  input wire logic clk,
  input wire logic irqLine,
  input wire logic fiqLine,
  output logic [1:0] seen
);
  always_ff @(posedge clk) begin
    seen <= {fiqLine, irqLine};
  end
endmodule : core_irq_model

//--- testbench/interrupt_mode_steering_tb_top.sv
// testbench: apb register and steering checks
`timescale 1ns/1ps
module interrupt_mode_steering_tb_top;
  import irq_steer_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irqOut, fiqOut;
  logic err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, intReq, rd, m, em;
  logic [5:0] extReq;
  logic [1:0] seen;
  int error_cnt, checked, seed, i, n;
  interrupt_mode_steering interrupt_mode_steering_inst (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .intReq(intReq), .extReq(extReq),
    .irqOut(irqOut), .fiqOut(fiqOut));
  core_irq_model core_irq_model_inst (.clk(clk), .irqLine(irqOut),
    .fiqLine(fiqOut), .seen(seen));
  task automatic chk(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // sample settled values before the edge that completes the access
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n == 20) begin
      error_cnt++;
      print_verdict();
    end
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // {fiq, irq}; reserved internal bits never count
  function automatic logic [1:0] expect_out(logic [31:0] r, md,
                                            logic [5:0] x, logic [31:0] xm);
    logic [31:0] v;
    v = r & INT_MODE_MASK;
    return {|(v & md) | |(x & xm[5:0]), |(v & ~md) | |(x & ~xm[5:0])};
  endfunction : expect_out
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'haec6829c;
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    intReq = 32'h0;
    extReq = 6'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFS_INT_MODE, 32'h0);
    chk(rd, RST_INT_MODE, "int mode reset");
    apb(1'b0, OFS_EXT_MODE, 32'h0);
    chk(rd, RST_EXT_MODE, "ext mode reset");
    for (i = 0; i < 4; i++) begin
      m = (i == 0) ? 32'hffff_ffff : $random(seed);
      em = (i == 0) ? 32'h0 : $random(seed);
      apb(1'b1, OFS_INT_MODE, m);
      apb(1'b1, OFS_EXT_MODE, em);
      apb(1'b0, OFS_INT_MODE, 32'h0);
      chk(rd, m & INT_MODE_MASK, "int mode");
      apb(1'b0, OFS_EXT_MODE, 32'h0);
      chk(rd, em & EXT_MODE_MASK, "ext mode");
      chk({31'h0, err}, 32'h0, "mapped error");
      apb(1'b1, 12'h008, m);
      chk({31'h0, err}, 32'h1, "unmapped error");
      for (int k = 0; k < 39; k++) begin
        intReq <= (k < 32) ? 32'h1 << k : (k == 38 ? $random(seed) : 0);
        extReq <= (k > 31 && k < 38) ? 6'h1 << (k - 32) : 6'h0;
        repeat (6) @(posedge clk);
        chk(seen, expect_out(intReq, m, extReq, em), "steer");
      end
      $display("test %0d done", i);
    end
    print_verdict();
  end
endmodule : interrupt_mode_steering_tb_top
